// File: design/sac_adc_ctrl.v
// converter control top: apb registers, clock selection, source decode, done flag
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"

module sac_adc_ctrl (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // oscillator and analog control
  input wire rc_osc_clk,
  input wire comparator_above,
  output wire rc_osc_enable,
  output wire converter_enable,
  output wire charge_pump_enable,
  output wire sample_switch,
  output wire [7:0] dac_code,
  output wire [`SAC_SRC_W-1:0] source_select
);

  // ==========================================================
  // bus handshake
  // one wait state: pready rises in the second access cycle, so the
  // read data and the error answer are both registered
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  wire access;
  wire first_access;
  wire commit;
  wire hit_ctrl;
  wire hit_result;
  wire ctrl_wr;
  wire result_rd;

  assign access = psel && penable;
  assign first_access = access && !pready_q;
  assign commit = access && pready_q;
  assign hit_ctrl = (paddr == `SAC_OFF_CTRL);
  assign hit_result = (paddr == `SAC_OFF_RESULT);
  assign ctrl_wr = commit && pwrite && hit_ctrl;
  assign result_rd = commit && !pwrite && hit_result;

  // ==========================================================
  // control and status state
  reg rcsel_q;
  reg pwr_q;
  reg [3:0] chan_q;
  reg done_flag_q;
  reg [7:0] result_q;
  reg restart_q;
  wire [7:0] ctrl_view;

  assign ctrl_view = {done_flag_q, rcsel_q, pwr_q, 1'b0, chan_q};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= first_access;
      pslverr_q <= first_access && !(hit_ctrl || hit_result);
      if (first_access && !pwrite) begin
        if (hit_ctrl) begin
          prdata_q <= {24'h00_0000, ctrl_view};
        end else if (hit_result) begin
          prdata_q <= {24'h00_0000, result_q};
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end else begin
        // read data stands only in the cycle that pready is high
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // control register
  // the done bit is read-only; writes to the result register are ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcsel_q <= 1'b0;
      pwr_q <= 1'b0;
      chan_q <= `SAC_CHAN_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= ctrl_wr;
      if (ctrl_wr) begin
        rcsel_q <= pwdata[`SAC_BIT_RCSEL];
        pwr_q <= pwdata[`SAC_BIT_PWR];
        chan_q <= pwdata[`SAC_CH_MSB:`SAC_CH_LSB];
      end
    end
  end

  // ==========================================================
  // conversion clock selection
  // the oscillator is asynchronous, so it is brought in through two
  // flops and only its rising edges count; this caps the rc rate at
  // one tick per two bus cycles but keeps the sequencer in one domain
  reg rc_s1_q;
  reg rc_s2_q;
  reg rc_s3_q;
  wire rc_rise;
  wire conv_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_osc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  assign rc_rise = rc_s2_q && !rc_s3_q;
  assign conv_tick = rcsel_q ? rc_rise : 1'b1;

  // ==========================================================
  // source multiplexer decode
  reg [`SAC_SRC_W-1:0] src_q;
  reg [`SAC_SRC_W-1:0] src_d;

  always @* begin
    src_d = {`SAC_SRC_W{1'b0}};
    if (chan_q <= `SAC_CH_EXT_LAST) begin
      src_d[chan_q[1:0]] = 1'b1;
    end else if (chan_q == `SAC_CH_REFH) begin
      src_d[`SAC_SRC_REFH] = 1'b1;
    end else if (chan_q == `SAC_CH_MID) begin
      src_d[`SAC_SRC_MID] = 1'b1;
    end else begin
      src_d[`SAC_SRC_REFL] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= {`SAC_SRC_W{1'b0}};
    end else begin
      src_q <= src_d;
    end
  end

  // ==========================================================
  // sequencer
  wire seq_done;
  wire [7:0] seq_result;
  wire seq_sample;
  wire [7:0] seq_dac;

  sac_sar_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwr_q),
    .restart(restart_q),
    .conv_tick(conv_tick),
    .comparator_above(comparator_above),
    .sample_q(seq_sample),
    .dac_q(seq_dac),
    .done_q(seq_done),
    .result_q(seq_result)
  );

  // ==========================================================
  // done flag and result register
  // there is no wait-state input on purpose: the flag and the sequencer
  // carry on whether or not the processor has read the last result
  reg done_flag_d;

  always @* begin
    done_flag_d = done_flag_q;
    if (seq_done) begin
      done_flag_d = 1'b1;
    end else if (ctrl_wr || result_rd) begin
      done_flag_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_q <= 1'b0;
      result_q <= `SAC_RESULT_RST;
    end else begin
      done_flag_q <= done_flag_d;
      if (seq_done) begin
        result_q <= seq_result;
      end
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rc_osc_enable = rcsel_q;
  assign converter_enable = pwr_q;
  assign charge_pump_enable = pwr_q;
  assign sample_switch = seq_sample;
  assign dac_code = seq_dac;
  assign source_select = src_q;

endmodule
`default_nettype wire

// File: design/sac_consts.vh
// register map, field positions, reset values and timing counts of the converter control
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ==========================================================
// register byte addresses
`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_RESULT 12'h004

// ==========================================================
// status/control fields
`define SAC_BIT_DONE 7
`define SAC_BIT_RCSEL 6
`define SAC_BIT_PWR 5
`define SAC_CH_MSB 3
`define SAC_CH_LSB 0
`define SAC_CTRL_RST 8'h00
`define SAC_CHAN_RST 4'h0
`define SAC_RESULT_RST 8'h00

// ==========================================================
// channel codes with special meaning
`define SAC_CH_EXT_LAST 4'h3
`define SAC_CH_REFH 4'h8
`define SAC_CH_MID 4'h9

// ==========================================================
// one-hot source select positions; 0..3 are the external inputs
`define SAC_SRC_REFL 4
`define SAC_SRC_REFH 5
`define SAC_SRC_MID 6
`define SAC_SRC_W 7

// ==========================================================
// timing
`define SAC_SAMPLE_CYC 4'hc
`define SAC_CONV_TICKS 6'h20
`define SAC_DAC_MSB 8'h80

`endif

// File: design/sac_sar_seq.v
// successive-approximation sequencer: sampling window, bit decisions, result
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"

module sac_sar_seq (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  input wire restart,
  input wire conv_tick,
  // analog side
  input wire comparator_above,
  output reg sample_q,
  output reg [7:0] dac_q,
  // result
  output reg done_q,
  output reg [7:0] result_q
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  reg [2:0] state_q;
  reg [3:0] samp_cnt_q;
  reg [5:0] tick_cnt_q;
  reg [7:0] mask_q;
  wire last_tick;
  wire [7:0] kept;

  assign last_tick = conv_tick && (tick_cnt_q == `SAC_CONV_TICKS - 6'h01);
  // the trial bit stays only when the input is at or above the dac level
  assign kept = comparator_above ? dac_q : (dac_q & ~mask_q);

  // ==========================================================
  // sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      samp_cnt_q <= 4'h0;
      tick_cnt_q <= 6'h00;
      mask_q <= 8'h00;
      sample_q <= 1'b0;
      dac_q <= 8'h00;
      done_q <= 1'b0;
      result_q <= `SAC_RESULT_RST;
    end else begin
      done_q <= 1'b0;
      if (!run) begin
        state_q <= ST_IDLE;
        sample_q <= 1'b0;
        mask_q <= 8'h00;
      end else if (restart) begin
        // abort whatever was in flight and begin a fresh period
        state_q <= ST_SAMPLE;
        samp_cnt_q <= 4'h0;
        tick_cnt_q <= 6'h00;
        sample_q <= 1'b1;
        mask_q <= 8'h00;
      end else begin
        if (conv_tick) begin
          tick_cnt_q <= last_tick ? 6'h00 : tick_cnt_q + 6'h01;
        end
        case (state_q)
          ST_SAMPLE: begin
            // window counts bus cycles, never conversion ticks
            if (samp_cnt_q == `SAC_SAMPLE_CYC - 4'h1) begin
              sample_q <= 1'b0;
              state_q <= ST_CONV;
              mask_q <= `SAC_DAC_MSB;
              dac_q <= `SAC_DAC_MSB;
            end else begin
              samp_cnt_q <= samp_cnt_q + 4'h1;
            end
          end
          ST_CONV: begin
            if (conv_tick && mask_q != 8'h00) begin
              dac_q <= kept | (mask_q >> 1);
              mask_q <= mask_q >> 1;
            end
            if (last_tick) begin
              done_q <= 1'b1;
              result_q <= dac_q;
              state_q <= ST_SAMPLE;
              samp_cnt_q <= 4'h0;
              sample_q <= 1'b1;
            end
          end
          ST_IDLE: begin
            sample_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            sample_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/sac_adc_asserts.sv
// concurrent port checks of the converter control top
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
// ==========================================================
// checker
module sac_adc_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // analog side
  input wire logic rc_osc_clk,
  input wire logic comparator_above,
  input wire logic rc_osc_enable,
  input wire logic converter_enable,
  input wire logic charge_pump_enable,
  input wire logic sample_switch,
  input wire logic [7:0] dac_code,
  input wire logic [`SAC_SRC_W-1:0] source_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a control write restarts the sequencer, so window checks are dropped then
  wire logic wr_ctl = psel && penable && pready && pwrite && paddr == `SAC_OFF_CTRL;

  chk_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  chk_slverr_map: assert property (pready |-> pslverr == (paddr != `SAC_OFF_CTRL && paddr != `SAC_OFF_RESULT))
    else $error("pslverr decode wrong");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  chk_pump_pair: assert property (converter_enable == charge_pump_enable)
    else $error("pump and converter enables differ");
  chk_src_onehot: assert property ($onehot0(source_select)) else $error("source not one-hot");
  chk_reset_off: assert property ($rose(presetn) |-> !rc_osc_enable && !converter_enable)
    else $error("enables set after reset");
  chk_sample_len: assert property (@(posedge pclk) disable iff (!presetn || wr_ctl)
    $rose(sample_switch) |-> sample_switch[*8] ##1 sample_switch[*4] ##1 !sample_switch)
    else $error("sampling window not 12 cycles");
  chk_dac_start: assert property ($fell(sample_switch) && converter_enable |-> dac_code == `SAC_DAC_MSB)
    else $error("first trial code wrong");
  chk_period: assert property (@(posedge pclk) disable iff (!presetn || wr_ctl)
    $rose(sample_switch) && !rc_osc_enable |-> ##32 $rose(sample_switch))
    else $error("conversion period not 32");

  cov_sample: cover property ($rose(sample_switch));
  cov_err: cover property (pready && pslverr);
  cov_rc: cover property (rc_osc_enable && sample_switch);
endmodule

bind sac_adc_ctrl sac_adc_asserts sac_adc_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rc_osc_clk(rc_osc_clk), .comparator_above(comparator_above),
  .rc_osc_enable(rc_osc_enable), .converter_enable(converter_enable), .charge_pump_enable(charge_pump_enable),
  .sample_switch(sample_switch), .dac_code(dac_code), .source_select(source_select));
`default_nettype wire

// File: verif/sac_analog_model.sv
// analog side model: input mux, sample capacitor and comparator
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
// ==========================================================
// model
module sac_analog_model (
  // clock
  input wire logic pclk,
  // from the control block
  input wire logic sample_switch,
  input wire logic [7:0] dac_code,
  input wire logic [`SAC_SRC_W-1:0] source_select,
  // external input levels, one byte each
  input wire logic [31:0] ext_levels,
  // to the control block
  output logic comparator_above
);
  logic [7:0] live;
  logic [7:0] held = 8'h00;
  always_comb begin
    live = 8'h00; // low reference
    for (int i = 0; i < 4; i++)
      if (source_select[i]) live = ext_levels[i*8 +: 8];
    if (source_select[`SAC_SRC_REFH]) live = 8'hff;
    if (source_select[`SAC_SRC_MID]) live = 8'h80;
  end
  // the capacitor only follows the input while the switch is closed
  always @(posedge pclk) if (sample_switch) held <= live;
  assign comparator_above = held >= dac_code;
endmodule
`default_nettype wire

// File: verif/sac_tb.sv
// self-checking testbench of the converter control top
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
// ==========================================================
// testbench
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rc_osc_clk = 1'b0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, ext = 32'h0, seed = 32'h6764, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, comparator_above, rc_osc_enable, converter_enable, charge_pump_enable, sample_switch;
  wire logic [7:0] dac_code;
  wire logic [`SAC_SRC_W-1:0] source_select;
  int err_total = 0, checks_done = 0;

  initial forever #12.5 pclk = ~pclk;
  // free-running oscillator, phase unrelated to the bus clock
  initial forever #18.5 rc_osc_clk = ~rc_osc_clk;

  sac_adc_ctrl sac_adc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_clk(rc_osc_clk), .comparator_above(comparator_above), .rc_osc_enable(rc_osc_enable),
    .converter_enable(converter_enable), .charge_pump_enable(charge_pump_enable),
    .sample_switch(sample_switch), .dac_code(dac_code), .source_select(source_select));
  sac_analog_model sac_analog_model_i (.pclk(pclk), .sample_switch(sample_switch), .dac_code(dac_code),
    .source_select(source_select), .ext_levels(ext), .comparator_above(comparator_above));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] lvl(input int ch);
    if (ch < 4) return ext[ch*8 +: 8];
    return ch == 8 ? 8'hff : ch == 9 ? 8'h80 : 8'h00;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do apb(1'b0, `SAC_OFF_CTRL, 32'h0); while (rd[7] !== 1'b1 && ++n < 100);
    if (n >= 100) err_total++;
  endtask

  // upper and reserved bits are random: they must be ignored
  task automatic wctl(input logic rc, pw, input logic [3:0] ch);
    logic [31:0] d;
    d = rnd();
    d[6] = rc;
    d[5] = pw;
    d[3:0] = ch;
    apb(1'b1, `SAC_OFF_CTRL, d);
    apb(1'b0, `SAC_OFF_CTRL, 32'h0);
    check("ctrl", {25'h0, rc, pw, 1'b0, ch}, rd);
  endtask

  task automatic conv(input logic rc, input logic [3:0] ch);
    wctl(rc, 1'b1, ch);
    wait_done();
    apb(1'b0, `SAC_OFF_RESULT, 32'h0);
    check("result", {24'h0, lvl(ch)}, rd);
    apb(1'b0, `SAC_OFF_CTRL, 32'h0);
    check("done cleared", {25'h0, rc, 2'b10, ch}, rd);
  endtask

  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    err_total++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ext <= rnd();
    @(posedge pclk);
    apb(1'b0, `SAC_OFF_CTRL, 32'h0);
    check("ctrl reset", 32'h0, rd);
    apb(1'b0, `SAC_OFF_RESULT, 32'h0);
    check("result reset", 32'h0, rd);
    apb(1'b1, 12'h008, rnd());
    check("unmapped error", 32'h1, {31'h0, err});
    for (int c = 0; c < 16; c++) conv(1'b0, 4'(c));
    conv(1'b0, 4'h2);
    ext <= rnd();
    wait_done();
    // flag left set: the next result must still overwrite
    repeat (40) @(posedge pclk);
    apb(1'b0, `SAC_OFF_RESULT, 32'h0);
    check("overwrite", {24'h0, lvl(2)}, rd);
    wctl(1'b0, 1'b1, 4'h8);
    repeat (10) @(posedge pclk);
    wctl(1'b0, 1'b1, 4'h9);
    wait_done();
    apb(1'b0, `SAC_OFF_RESULT, 32'h0);
    check("abort restart", 32'h80, rd);
    wctl(1'b1, 1'b0, 4'h0);
    repeat (20) @(posedge pclk);
    check("rc alone", 32'h1, {31'h0, rc_osc_enable & ~converter_enable});
    conv(1'b1, 4'h0);
    check("rc enable", 32'h1, {31'h0, rc_osc_enable});
    wctl(1'b1, 1'b0, 4'h3);
    check("converter off", 32'h0, {31'h0, converter_enable});
    repeat (100) @(posedge pclk);
    apb(1'b0, `SAC_OFF_CTRL, 32'h0);
    check("idle no done", 32'h43, rd);
    wctl(1'b0, 1'b0, 4'h0);
    check("all off", 32'h0, {30'h0, rc_osc_enable, charge_pump_enable});
    final_report();
  end
endmodule
`default_nettype wire
